/* File: include/omc_pkg.sv */
// package: register map, field layout, reset values and mode codes
package omc_pkg;

    ////////////////////////////////////////////////////////////////////
    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_CTRL_ONE = 6'h38;
    localparam logic [5:0] IDX_CTRL_TWO = 6'h39;

    ////////////////////////////////////////////////////////////////////
    // system_control_one field positions
    localparam int B1_STOP   = 7;
    localparam int B1_REL_LEVEL = 6;
    localparam int B1_POST_SLOW = 5;
    localparam int B1_PORT_HOLD = 4;
    localparam int B1_WARM_HI   = 3;
    localparam int B1_WARM_LO   = 2;

    // system_control_two field positions
    localparam int B2_FAST_EN   = 7;
    localparam int B2_SLOW_EN   = 6;
    localparam int B2_CLK_SEL   = 5;
    localparam int B2_IDLE      = 4;
    localparam int B2_GATE_HALT = 2;

    ////////////////////////////////////////////////////////////////////
    // reset values of the stored fields
    localparam logic [7:0] RST_CTRL_ONE = 8'h00;
    localparam logic [7:0] RST_CTRL_TWO = 8'h80;

    ////////////////////////////////////////////////////////////////////
    // warm-up lengths, return to fast clock, in fast-clock periods
    localparam int unsigned WARM_FAST_00 = 3 * (2 ** 16);
    localparam int unsigned WARM_FAST_01 = 2 ** 16;
    localparam int unsigned WARM_FAST_10 = 3 * (2 ** 14);
    localparam int unsigned WARM_FAST_11 = 2 ** 14;
    // warm-up lengths, return to slow clock, in slow-clock periods
    localparam int unsigned WARM_SLOW_00 = 3 * (2 ** 13);
    localparam int unsigned WARM_SLOW_01 = 2 ** 13;
    localparam int unsigned WARM_SLOW_10 = 3 * (2 ** 6);
    localparam int unsigned WARM_SLOW_11 = 2 ** 6;

    localparam int CNT_W = 18;

    ////////////////////////////////////////////////////////////////////
    // operating states, one-hot
    typedef enum logic [4:0] {
        ST_RUN     = 5'h01,
        ST_HALT    = 5'h02,
        ST_GATE    = 5'h04,
        ST_STOP    = 5'h08,
        ST_WARM    = 5'h10
    } omc_state_t;

endpackage

/* File: verilog/omc_top.sv */
// operating mode controller: stop, warm-up, idle/sleep and clock control
`timescale 1ns/1ps

// How it works
// - writing one to stop bit halts oscillators, core and peripherals
// - release select: zero wakes on pin edge, one on pin or key level
// - post-stop select: zero resumes fast normal, one resumes slow, fast off
// - while stopped, hold bit zero floats port outputs, one keeps driving
// - two-bit field picks warm-up length from fast or slow table
// - reset pin ends stop with normal reset into single-clock fast mode
// - unused bits of both registers read back undefined, here zero
// - stop with hold bit zero forces port inputs to zero
// - shared stop pin floats during stop regardless of hold bit
// - oscillator enables stop or run each oscillator; fast one resets set
// - clock select writes choose core clock; reads report clock in use
// - core halt bit stops cpu and watchdog, peripherals keep running
// - clock-gate halt bit stops peripheral clocks except time base
// - reset when both enables cleared or selected clock's enable cleared
// - hardware clears core halt bit on release
// - hardware clears clock-gate halt bit on release, possibly early
// - stop entry clears prescaler and divider, state otherwise kept
// - program counter holds address two past stop instruction while stopped
// - level release ends stop while pin high or key active, even at once
// - edge release ends stop on pin rising edge, entered even if high
// - after warm-up with everything held, execution resumes
module omc_top #(
    parameter int unsigned WARM_FAST_00 = omc_pkg::WARM_FAST_00,
    parameter int unsigned WARM_FAST_01 = omc_pkg::WARM_FAST_01,
    parameter int unsigned WARM_FAST_10 = omc_pkg::WARM_FAST_10,
    parameter int unsigned WARM_FAST_11 = omc_pkg::WARM_FAST_11,
    parameter int unsigned WARM_SLOW_00 = omc_pkg::WARM_SLOW_00,
    parameter int unsigned WARM_SLOW_01 = omc_pkg::WARM_SLOW_01
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        stop_pin_n_i,
    input  wire logic [3:0]  key_wake_i,
    input  wire logic [3:0]  key_wake_en_i,
    input  wire logic        slow_tick_i,
    input  wire logic        wake_event_i,
    input  wire logic        time_base_edge_i,
    output logic             fast_osc_en_o,
    output logic             slow_osc_en_o,
    output logic             sys_clk_sel_o,
    output logic             core_halt_o,
    output logic             periph_gate_o,
    output logic             stop_active_o,
    output logic             warmup_active_o,
    output logic             port_hiz_o,
    output logic             port_in_zero_o,
    output logic             stop_pin_hiz_o,
    output logic             pc_hold_o,
    output logic             tg_clear_o,
    output logic             reset_req_o
);

    ////////////////////////////////////////////////////////////////////
    // whole module state
    typedef struct packed {
        omc_pkg::omc_state_t           st;
        logic                          ack;
        logic [31:0]                   dat;
        logic                          stop;
        logic                          rel_level;
        logic                          post_slow;
        logic                          port_hold;
        logic [1:0]                    warm_sel;
        logic                          fast_en;
        logic                          slow_en;
        logic                          clk_sel;
        logic                          clk_used;
        logic                          idle;
        logic                          gate_halt;
        logic                          pin_q;
        logic [omc_pkg::CNT_W-1:0]     cnt;
        logic                          o_fast;
        logic                          o_slow;
        logic                          o_core;
        logic                          o_gate;
        logic                          o_hiz;
        logic                          o_pin_hiz;
        logic                          o_hold;
        logic                          o_stop;
        logic                          o_warm;
        logic                          tg_clear;
        logic                          reset_req;
    } omc_regs_t;

    omc_regs_t s;
    omc_regs_t next_s;

    logic req;
    logic wr_one;
    logic wr_two;
    logic wake_lvl;
    logic wake_edge;
    logic tick;

    ////////////////////////////////////////////////////////////////////
    // warm-up length lookup from mode and field
    function automatic logic [omc_pkg::CNT_W-1:0] warm_len(
        input logic       slow,
        input logic [1:0] code
    );
        int unsigned v;
        v = 0;
        case ({slow, code})
            3'h0:    v = WARM_FAST_00;
            3'h1:    v = WARM_FAST_01;
            3'h2:    v = WARM_FAST_10;
            3'h3:    v = WARM_FAST_11;
            3'h4:    v = WARM_SLOW_00;
            3'h5:    v = WARM_SLOW_01;
            3'h6:    v = omc_pkg::WARM_SLOW_10;
            default: v = omc_pkg::WARM_SLOW_11;
        endcase
        return omc_pkg::CNT_W'(v);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // bus decode and wake conditions
    assign req       = cyc_i & stb_i & ~s.ack;
    assign wr_one    = req & we_i & sel_i[0]
                     & (adr_i[7:2] == omc_pkg::IDX_CTRL_ONE);
    assign wr_two    = req & we_i & sel_i[0]
                     & (adr_i[7:2] == omc_pkg::IDX_CTRL_TWO);
    assign wake_lvl  = stop_pin_n_i | (|(key_wake_i & key_wake_en_i));
    assign wake_edge = stop_pin_n_i & ~s.pin_q;
    assign tick      = s.post_slow ? slow_tick_i : 1'b1;

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        next_s           = s;
        next_s.ack       = req;
        next_s.tg_clear  = 1'b0;
        next_s.reset_req = 1'b0;
        next_s.pin_q     = stop_pin_n_i;
        next_s.clk_used  = s.clk_sel;

        // register read; undefined bits as zero
        if (req) begin
            next_s.dat = 32'h0000_0000;
            if (adr_i[7:2] == omc_pkg::IDX_CTRL_ONE) begin
                next_s.dat[omc_pkg::B1_STOP]  = s.stop;
                next_s.dat[omc_pkg::B1_REL_LEVEL] = s.rel_level;
                next_s.dat[omc_pkg::B1_POST_SLOW] = s.post_slow;
                next_s.dat[omc_pkg::B1_PORT_HOLD] = s.port_hold;
                next_s.dat[omc_pkg::B1_WARM_HI:omc_pkg::B1_WARM_LO]
                    = s.warm_sel;
            end else if (adr_i[7:2] == omc_pkg::IDX_CTRL_TWO) begin
                next_s.dat[omc_pkg::B2_FAST_EN]   = s.fast_en;
                next_s.dat[omc_pkg::B2_SLOW_EN]   = s.slow_en;
                next_s.dat[omc_pkg::B2_CLK_SEL]   = s.clk_used;
                next_s.dat[omc_pkg::B2_IDLE]      = s.idle;
                next_s.dat[omc_pkg::B2_GATE_HALT] = s.gate_halt;
            end
        end

        // control writes only land while running
        if (wr_one && s.st == omc_pkg::ST_RUN) begin
            next_s.rel_level = dat_i[omc_pkg::B1_REL_LEVEL];
            next_s.post_slow = dat_i[omc_pkg::B1_POST_SLOW];
            next_s.port_hold = dat_i[omc_pkg::B1_PORT_HOLD];
            next_s.warm_sel  = dat_i[omc_pkg::B1_WARM_HI:omc_pkg::B1_WARM_LO];
            next_s.stop  = dat_i[omc_pkg::B1_STOP];
        end
        if (wr_two && s.st == omc_pkg::ST_RUN) begin
            next_s.fast_en   = dat_i[omc_pkg::B2_FAST_EN];
            next_s.slow_en   = dat_i[omc_pkg::B2_SLOW_EN];
            next_s.clk_sel   = dat_i[omc_pkg::B2_CLK_SEL];
            next_s.idle      = dat_i[omc_pkg::B2_IDLE];
            // core halt wins if both set
            next_s.gate_halt = dat_i[omc_pkg::B2_GATE_HALT]
                             & ~dat_i[omc_pkg::B2_IDLE];
            next_s.reset_req = (~next_s.fast_en & ~next_s.slow_en)
                             | (~next_s.fast_en & ~next_s.clk_sel)
                             | (~next_s.slow_en & next_s.clk_sel);
        end

        // mode sequencing
        case (s.st)
            omc_pkg::ST_RUN: begin
                if (s.stop) begin
                    next_s.tg_clear = 1'b1;
                    // level already true: warm up at once
                    if (s.rel_level && wake_lvl) begin
                        next_s.st  = omc_pkg::ST_WARM;
                        next_s.cnt = warm_len(s.post_slow, s.warm_sel);
                    end else begin
                        next_s.st = omc_pkg::ST_STOP;
                    end
                end else if (s.idle) begin
                    next_s.st = omc_pkg::ST_HALT;
                end else if (s.gate_halt) begin
                    next_s.st = omc_pkg::ST_GATE;
                end
            end
            omc_pkg::ST_STOP: begin
                if (s.rel_level ? wake_lvl : wake_edge) begin
                    next_s.st  = omc_pkg::ST_WARM;
                    next_s.cnt = warm_len(s.post_slow, s.warm_sel);
                end
            end
            omc_pkg::ST_WARM: begin
                if (tick) begin
                    if (s.cnt <= omc_pkg::CNT_W'(1)) begin
                        next_s.st   = omc_pkg::ST_RUN;
                        next_s.stop = 1'b0;
                        next_s.clk_sel = s.post_slow;
                        next_s.fast_en = ~s.post_slow;
                        next_s.slow_en = s.slow_en | s.post_slow;
                    end else begin
                        next_s.cnt = s.cnt - omc_pkg::CNT_W'(1);
                    end
                end
            end
            omc_pkg::ST_HALT: begin
                if (wake_event_i) begin
                    next_s.idle = 1'b0;
                    next_s.st   = omc_pkg::ST_RUN;
                end
            end
            omc_pkg::ST_GATE: begin
                if (time_base_edge_i) begin
                    next_s.gate_halt = 1'b0;
                    next_s.st     = omc_pkg::ST_RUN;
                end
            end
            default: begin
                next_s.st = omc_pkg::ST_RUN;
            end
        endcase

        // registered outputs from the next state
        case (next_s.st)
            omc_pkg::ST_STOP: begin
                next_s.o_fast = 1'b0;
                next_s.o_slow = 1'b0;
            end
            omc_pkg::ST_WARM: begin
                next_s.o_fast = ~next_s.post_slow;
                next_s.o_slow = next_s.post_slow | next_s.slow_en;
            end
            default: begin
                next_s.o_fast = next_s.fast_en;
                next_s.o_slow = next_s.slow_en;
            end
        endcase
        next_s.o_core = (next_s.st != omc_pkg::ST_RUN);
        next_s.o_gate = (next_s.st == omc_pkg::ST_GATE)
                      | (next_s.st == omc_pkg::ST_STOP)
                      | (next_s.st == omc_pkg::ST_WARM);
        // outputs float and inputs forced low unless held
        next_s.o_hiz  = ((next_s.st == omc_pkg::ST_STOP)
                      | (next_s.st == omc_pkg::ST_WARM)) & ~next_s.port_hold;
        next_s.o_pin_hiz = (next_s.st == omc_pkg::ST_STOP)
                         | (next_s.st == omc_pkg::ST_WARM);
        next_s.o_hold = next_s.o_core;
        // mode flags, registered so the outputs come from flops
        next_s.o_stop = (next_s.st == omc_pkg::ST_STOP);
        next_s.o_warm = (next_s.st == omc_pkg::ST_WARM);
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // reset returns to single-clock fast run
            s          <= '0;
            s.st       <= omc_pkg::ST_RUN;
            s.stop     <= omc_pkg::RST_CTRL_ONE[omc_pkg::B1_STOP];
            s.fast_en  <= omc_pkg::RST_CTRL_TWO[omc_pkg::B2_FAST_EN];
            s.slow_en  <= omc_pkg::RST_CTRL_TWO[omc_pkg::B2_SLOW_EN];
            s.o_fast   <= omc_pkg::RST_CTRL_TWO[omc_pkg::B2_FAST_EN];
            s.pin_q    <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign dat_o           = s.dat;
    assign ack_o           = s.ack;
    assign fast_osc_en_o   = s.o_fast;
    assign slow_osc_en_o   = s.o_slow;
    assign sys_clk_sel_o   = s.clk_sel;
    assign core_halt_o     = s.o_core;
    assign periph_gate_o   = s.o_gate;
    assign stop_active_o   = s.o_stop;
    assign warmup_active_o = s.o_warm;
    assign port_hiz_o      = s.o_hiz;
    assign port_in_zero_o  = s.o_hiz;
    assign stop_pin_hiz_o  = s.o_pin_hiz;
    assign pc_hold_o       = s.o_hold;
    assign tg_clear_o      = s.tg_clear;
    assign reset_req_o     = s.reset_req;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_stop_req;
        s.st == omc_pkg::ST_RUN && s.stop && !(s.rel_level && wake_lvl);
    endsequence
    sequence seq_in_stop;
        s.st == omc_pkg::ST_STOP && !fast_osc_en_o && !slow_osc_en_o;
    endsequence

    AST_ACK_PULSE: assert property (req |=> ack_o ##1 !ack_o)
        else $error("ack not a single pulse");
    AST_STOP_ENTER: assert property (seq_stop_req |=> seq_in_stop)
        else $error("stop not entered with oscillators off");
    AST_EDGE_WAKE: assert property (
        s.st == omc_pkg::ST_STOP && !s.rel_level && wake_edge
        |=> s.st == omc_pkg::ST_WARM)
        else $error("edge release missed");
    AST_EDGE_NO_LVL: assert property (
        s.st == omc_pkg::ST_STOP && !s.rel_level && !wake_edge
        |=> s.st == omc_pkg::ST_STOP)
        else $error("edge mode woke on level");
    AST_LEVEL_NOW: assert property (
        s.st == omc_pkg::ST_RUN && s.stop && s.rel_level && wake_lvl
        |=> s.st == omc_pkg::ST_WARM && tg_clear_o)
        else $error("level release did not warm up at once");
    AST_RESUME_MODE: assert property (
        s.st == omc_pkg::ST_WARM && tick && s.cnt == 18'h00001
        |=> s.st == omc_pkg::ST_RUN && sys_clk_sel_o == $past(s.post_slow)
            && fast_osc_en_o == !$past(s.post_slow))
        else $error("wrong mode after warm-up");
    AST_HIZ: assert property (
        s.st == omc_pkg::ST_STOP |-> port_hiz_o == !s.port_hold
            && port_in_zero_o == !s.port_hold && stop_pin_hiz_o)
        else $error("port float wrong in stop");
    AST_TG_CLEAR: assert property (
        seq_stop_req |=> tg_clear_o ##1 !tg_clear_o)
        else $error("divider clear not pulsed on stop entry");
    AST_IDLE_CLR: assert property (
        s.st == omc_pkg::ST_HALT && wake_event_i
        |=> !s.idle && !core_halt_o)
        else $error("core halt bit not cleared");
    AST_GATE_CLR: assert property (
        s.st == omc_pkg::ST_GATE && time_base_edge_i
        |=> !s.gate_halt && !periph_gate_o)
        else $error("gate halt bit not cleared");
    AST_OSC_RESET: assert property (
        wr_two && s.st == omc_pkg::ST_RUN
        && !dat_i[omc_pkg::B2_FAST_EN] && !dat_i[omc_pkg::B2_SLOW_EN]
        |=> reset_req_o)
        else $error("no reset on both oscillators off");

endmodule

/* File: test/omc_wake_model.sv */
// wake-side model: stop pin and key wake inputs that follow with a lag
`timescale 1ns/1ps
module omc_wake_model (
    input  wire logic       clk_i,
    input  wire logic       pin_req_i,
    input  wire logic [3:0] key_req_i,
    input  wire logic [3:0] lag_i,
    output logic            stop_pin_n_o,
    output logic      [3:0] key_wake_o
);
    logic [3:0] wait_cnt;

    // pin idles high, keys idle inactive
    initial begin
        stop_pin_n_o = 1'b1;
        key_wake_o = 4'h0;
        wait_cnt = 4'h0;
    end

    // follow the requested levels lag_i + 1 cycles after they change
    // keys serve only as level wake sources
    always @(posedge clk_i) begin
        if ({pin_req_i, key_req_i} === {stop_pin_n_o, key_wake_o}) begin
            wait_cnt <= 4'h0;
        end else if (wait_cnt >= lag_i) begin
            stop_pin_n_o <= pin_req_i;
            key_wake_o <= key_req_i;
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

/* File: test/omc_top_bench.sv */
// self-checking bench for the operating mode controller
`timescale 1ns/1ps
module omc_top_bench;
    localparam logic [7:0] A1 = {omc_pkg::IDX_CTRL_ONE, 2'b00};
    localparam logic [7:0] A2 = {omc_pkg::IDX_CTRL_TWO, 2'b00};
    localparam int WF [4] = '{16, 12, 8, 6};
    localparam int WS [4] = '{12, 10, 192, 64};
    localparam logic [7:0] PRE [3] = '{8'hc0, 8'hc0, 8'he0};
    localparam logic [7:0] BAD [3] = '{8'h00, 8'h40, 8'ha0};

    logic        clk_i, rst_i, cyc_i, stb_i, we_i, slow_tick_i;
    logic        wake_event_i, time_base_edge_i, ack_o, pin_req;
    logic [7:0]  adr_i;
    logic [31:0] dat_i, dat_o;
    logic [3:0]  key_req;
    logic [1:0]  tick_div;
    wire         stop_pin_n_i;
    wire  [3:0]  key_wake_i;
    logic        fast_osc_en_o, slow_osc_en_o, sys_clk_sel_o, core_halt_o;
    logic        periph_gate_o, stop_active_o, warmup_active_o, port_hiz_o;
    logic        port_in_zero_o, stop_pin_hiz_o, pc_hold_o, tg_clear_o;
    logic        reset_req_o;
    int          fails = 0, num_checks = 0, tg_n = 0, rr_n = 0;
    int          wc = 0, wt = 0, st_n = 0;

    omc_top #(.WARM_FAST_00(WF[0]), .WARM_FAST_01(WF[1]),
        .WARM_FAST_10(WF[2]), .WARM_FAST_11(WF[3]),
        .WARM_SLOW_00(WS[0]), .WARM_SLOW_01(WS[1])) dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .stop_pin_n_i(stop_pin_n_i),
        .key_wake_i(key_wake_i), .key_wake_en_i(4'h1),
        .slow_tick_i(slow_tick_i), .wake_event_i(wake_event_i),
        .time_base_edge_i(time_base_edge_i),
        .fast_osc_en_o(fast_osc_en_o),
        .slow_osc_en_o(slow_osc_en_o), .sys_clk_sel_o(sys_clk_sel_o),
        .core_halt_o(core_halt_o), .periph_gate_o(periph_gate_o),
        .stop_active_o(stop_active_o), .warmup_active_o(warmup_active_o),
        .port_hiz_o(port_hiz_o), .port_in_zero_o(port_in_zero_o),
        .stop_pin_hiz_o(stop_pin_hiz_o), .pc_hold_o(pc_hold_o),
        .tg_clear_o(tg_clear_o), .reset_req_o(reset_req_o));

    omc_wake_model wake (.clk_i(clk_i), .pin_req_i(pin_req),
        .key_req_i(key_req), .lag_i(4'h3), .stop_pin_n_o(stop_pin_n_i),
        .key_wake_o(key_wake_i));

    ////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    always #5 clk_i = ~clk_i;

    // slow tick every fourth cycle; count pulses and mode cycles
    always @(posedge clk_i) begin
        tick_div <= tick_div + 2'h1;
        slow_tick_i <= (tick_div == 2'h3);
        if (tg_clear_o === 1'b1) tg_n <= tg_n + 1;
        if (reset_req_o === 1'b1) rr_n <= rr_n + 1;
        if (stop_active_o === 1'b1) st_n <= st_n + 1;
        if (warmup_active_o === 1'b1) wc <= wc + 1;
        if (warmup_active_o === 1'b1 && slow_tick_i === 1'b1) wt <= wt + 1;
    end

    ////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // compare a flag
    task automatic chk_bit(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    // compare a byte
    task automatic chk_byte(input string nm, input logic [7:0] e,
                            input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one classic bus cycle, held until ack is sampled
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o[7:0];
        chk_bit("ack", 1'b1, ack_o);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(a, 1'b0, 8'h00, q);
        chk_byte($sformatf("reg %h", a), e, q);
    endtask

    // wait, bounded, for a mode flag to reach a level
    task automatic wait_lvl(input int s, input logic v);
        logic x;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            case (s)
                0: x = stop_active_o;
                1: x = warmup_active_o;
                2: x = core_halt_o;
                default: x = periph_gate_o;
            endcase
        end while (x !== v && n < 3000);
        chk_bit($sformatf("mode %0d", s), v, x);
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int i, t0;
        logic [7:0] b;
        {clk_i, cyc_i, stb_i, we_i, slow_tick_i} = 5'h0;
        {wake_event_i, time_base_edge_i, tick_div} = 4'h0;
        {adr_i, dat_i, key_req} = 44'h0;
        pin_req = 1'b1;
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk_bit("fast_osc", 1'b1, fast_osc_en_o);
        rd(A1, 8'h00);
        rd(A2, 8'h80);
        wr(A2, 8'hcb);
        rd(A2, 8'hc0);
        chk_bit("slow_osc", 1'b1, slow_osc_en_o);
        wr(A1, 8'h13);
        rd(A1, 8'h10);
        wr(A2, 8'he0);
        rd(A2, 8'he0);
        chk_bit("clk_sel", 1'b1, sys_clk_sel_o);
        wr(A2, 8'hc0);
        rd(8'h00, 8'h00);
        wr(A2, 8'hd0);
        wait_lvl(2, 1'b1);
        chk_bit("gate", 1'b0, periph_gate_o);
        chk_bit("pc_hold", 1'b1, pc_hold_o);
        wr(A1, 8'h00);
        wake_event_i <= 1'b1;
        @(posedge clk_i);
        wake_event_i <= 1'b0;
        wait_lvl(2, 1'b0);
        rd(A2, 8'hc0);
        rd(A1, 8'h10);
        wr(A2, 8'hc4);
        wait_lvl(3, 1'b1);
        chk_bit("halt", 1'b1, core_halt_o);
        time_base_edge_i <= 1'b1;
        @(posedge clk_i);
        time_base_edge_i <= 1'b0;
        wait_lvl(3, 1'b0);
        rd(A2, 8'hc0);
        for (i = 0; i < 3; i++) begin
            wr(A2, PRE[i]);
            t0 = rr_n;
            wr(A2, BAD[i]);
            repeat (3) @(posedge clk_i);
            chk_bit("reset_req", 1'b1, rr_n == t0 + 1);
        end
        wr(A2, 8'hc0);
        for (i = 0; i < 4; i++) begin
            b = {3'b100, i[0], i[1:0], 2'b00};
            t0 = tg_n;
            wr(A1, b);
            wait_lvl(0, 1'b1);
            @(posedge clk_i);
            chk_bit("tg_clear", 1'b1, tg_n == t0 + 1);
            chk_bit("fast_osc", 1'b0, fast_osc_en_o);
            chk_bit("port_hiz", !i[0], port_hiz_o);
            chk_bit("in_zero", !i[0], port_in_zero_o);
            chk_bit("pin_hiz", 1'b1, stop_pin_hiz_o);
            key_req <= 4'h1;
            repeat (6) @(posedge clk_i);
            chk_bit("stop", 1'b1, stop_active_o);
            key_req <= 4'h0;
            pin_req <= 1'b0;
            repeat (6) @(posedge clk_i);
            t0 = wc;
            pin_req <= 1'b1;
            wait_lvl(1, 1'b1);
            wait_lvl(1, 1'b0);
            chk_byte("warm", 8'(WF[i]), 8'(wc - t0));
            chk_bit("clk_sel", 1'b0, sys_clk_sel_o);
            rd(A1, b & 8'h7c);
        end
        t0 = st_n;
        wr(A1, 8'hc0);
        wait_lvl(1, 1'b1);
        wait_lvl(1, 1'b0);
        chk_bit("no_stop", 1'b1, st_n == t0);
        pin_req <= 1'b0;
        for (i = 2; i < 4; i++) begin
            wr(A2, 8'he0);
            b = {4'b1111, i[1:0], 2'b00};
            wr(A1, b);
            wait_lvl(0, 1'b1);
            chk_bit("port_hiz", 1'b0, port_hiz_o);
            chk_bit("pin_hiz", 1'b1, stop_pin_hiz_o);
            // a key whose enable is off must not end stop
            key_req <= 4'h2;
            repeat (6) @(posedge clk_i);
            chk_bit("masked_key", 1'b1, stop_active_o);
            t0 = wt;
            key_req <= 4'h1;
            wait_lvl(1, 1'b1);
            wait_lvl(1, 1'b0);
            chk_bit("ticks", 1'b1, (wt - t0 - WS[i]) inside {-1, 0, 1});
            chk_bit("clk_sel", 1'b1, sys_clk_sel_o);
            chk_bit("fast_osc", 1'b0, fast_osc_en_o);
            key_req <= 4'h0;
            rd(A2, 8'h60);
            wr(A2, 8'hc0);
        end
        wr(A2, 8'he0);
        wr(A1, 8'he0);
        wait_lvl(0, 1'b1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk_bit("stop", 1'b0, stop_active_o);
        chk_bit("clk_sel", 1'b0, sys_clk_sel_o);
        chk_bit("fast_osc", 1'b1, fast_osc_en_o);
        rd(A2, 8'h80);
        complete_run();
    end

    // cut a hang short
    initial begin
        #200000;
        fails++;
        complete_run();
    end
endmodule
